// File: hw/hw_activation_consts.svh
// Constants for the hardware-control activation pin logic
`ifndef HW_ACTIVATION_CONSTS_SVH
`define HW_ACTIVATION_CONSTS_SVH

// Core clock rate in MHz (10 ns period)
`define HWAC_CLK_MHZ 64'd100
// Master activation timer period in milliseconds
`define HWAC_MAT_TIME_MS 64'd15000
// Master activation timer period in core clock cycles
`define HWAC_MAT_CYCLES (`HWAC_MAT_TIME_MS * 64'd1000 * `HWAC_CLK_MHZ)
// Width of the master activation timer counter
`define HWAC_MAT_WIDTH 32
// Operating modes that carry the loop number across the line
`define HWAC_OPMODE_LOOP_A 3'h6
`define HWAC_OPMODE_LOOP_B 3'h7
// Loop number value naming the first line loop
`define HWAC_LOOP_FIRST 1'h0
// Reset value of the synchronised pins (all pins have pull-downs)
`define HWAC_PIN_RESET 1'h0
// Edges after reset before the synchronised pins are trusted
`define HWAC_SETTLE_COUNT 3'h4

// Bit positions inside the synchronised pin bundle
`define HWAC_PIN_QUIET 0
`define HWAC_PIN_REQ 1
`define HWAC_PIN_MASTER 2
`define HWAC_PIN_LOOP 3
`define HWAC_PIN_OPMODE_LO 4
`define HWAC_PIN_OPMODE_HI 6
`define HWAC_PIN_SEL_A 7
`define HWAC_PIN_SEL_B 8
`define HWAC_PIN_SEL_C 9
`define HWAC_PIN_COUNT 10

`endif

// File: hw/hw_activation_pkg.sv
// Types shared by the activation pin logic
package hw_activation_pkg;

	typedef enum logic [1:0] {
		ST_DEACTIVATED,
		ST_ACTIVATING,
		ST_ACTIVE
	} act_state_t;

endpackage : hw_activation_pkg

// File: hw/act_timer_if.sv
// Control bundle between the activation controller and its timer
interface act_timer_if;
	logic start;
	logic stop;
	logic running;
	logic expired;

	modport ctrl (
		output start,
		output stop,
		input running,
		input expired
	);

	modport timer (
		input start,
		input stop,
		output running,
		output expired
	);
endinterface : act_timer_if

// File: hw/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`include "hw_activation_consts.svh"
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_pins
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] out_next;

	initial begin
		if (WIDTH < 1) begin
			$error("pin_sync needs WIDTH of at least 1");
		end
	end

	// A bit follows the pins only once stages two and three agree
	always_comb begin
		out_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (out_reg & (s2_reg ^ s3_reg));
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_reg <= {WIDTH{`HWAC_PIN_RESET}};
			s2_reg <= {WIDTH{`HWAC_PIN_RESET}};
			s3_reg <= {WIDTH{`HWAC_PIN_RESET}};
			out_reg <= {WIDTH{`HWAC_PIN_RESET}};
		end else begin
			s1_reg <= i_pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign o_pins = out_reg;
endmodule : pin_sync

// File: hw/act_timer.sv
// Master activation timer: one-shot down counter with expiry pulse
`include "hw_activation_consts.svh"
module act_timer #(
	parameter int WIDTH = `HWAC_MAT_WIDTH,
	parameter longint unsigned CYCLES = `HWAC_MAT_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	act_timer_if.timer tmr
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic run_reg;
	logic run_next;
	logic exp_reg;
	logic exp_next;

	initial begin
		if (CYCLES < 1 || CYCLES > ((64'h1 << WIDTH) - 64'h1)) begin
			$error("act_timer CYCLES does not fit WIDTH");
		end
	end

	always_comb begin
		count_next = count_reg;
		run_next = run_reg;
		exp_next = 1'b0;
		if (tmr.stop) begin
			run_next = 1'b0;
		end else if (tmr.start) begin
			// Restart always reloads, so a late start cannot inherit a stale count
			count_next = WIDTH'(CYCLES - 64'h1);
			run_next = 1'b1;
		end else if (run_reg) begin
			if (count_reg == '0) begin
				run_next = 1'b0;
				exp_next = 1'b1;
			end else begin
				count_next = count_reg - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			count_reg <= '0;
			run_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end

	assign tmr.running = run_reg;
	assign tmr.expired = exp_reg;
endmodule : act_timer

// File: hw/hw_activation_control.sv
// Hardware-control-mode activation pin logic of the line transceiver
`include "hw_activation_consts.svh"
module hw_activation_control #(
	parameter longint unsigned MAT_CYCLES = `HWAC_MAT_CYCLES,
	parameter int MAT_WIDTH = `HWAC_MAT_WIDTH
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_quiet,
	input wire logic i_activation_request_in,
	input wire logic i_hw_mode_select_a,
	input wire logic i_hw_mode_select_b,
	input wire logic i_hw_mode_select_c,
	input wire logic i_master_mode,
	input wire logic [2:0] i_operating_mode,
	input wire logic i_loop_number_io,
	output logic o_loop_number_io,
	output logic o_loop_number_io_oe_n,
	input wire logic i_sw_activate,
	input wire logic i_sw_deactivate,
	input wire logic i_line_wake,
	input wire logic i_train_done,
	input wire logic i_line_lost,
	input wire logic i_rx_loop_number,
	output logic o_tx_loop_number,
	output logic o_tx_loop_number_en,
	output logic o_loop_number_valid,
	output logic o_first_loop,
	output logic o_activating_flag_out,
	output logic o_activation_timeout_flag,
	output logic o_hw_control_mode,
	output logic o_deactivated,
	output logic o_active
);
	logic [`HWAC_PIN_COUNT-1:0] pins_raw;
	logic [`HWAC_PIN_COUNT-1:0] pins;
	logic quiet;
	logic req;
	logic master;
	logic loop_in;
	logic [2:0] opmode;
	logic hw_mode;
	logic loop_mode;
	logic req_prev_reg;
	logic req_prev_next;
	logic req_rise;
	logic start_req;
	logic stop_req;
	logic [2:0] settle_reg;
	logic [2:0] settle_next;
	logic settled;

	hw_activation_pkg::act_state_t state_reg;
	hw_activation_pkg::act_state_t state_next;
	logic timeout_reg;
	logic timeout_next;
	logic tx_loop_reg;
	logic tx_loop_next;
	logic tx_en_reg;
	logic tx_en_next;
	logic rx_loop_reg;
	logic rx_loop_next;
	logic pin_oe_n_reg;
	logic pin_oe_n_next;
	logic valid_reg;
	logic valid_next;
	logic first_reg;
	logic first_next;

	act_timer_if tmr_if ();

	function automatic logic is_loop_mode(input logic [2:0] mode);
		is_loop_mode = (mode == `HWAC_OPMODE_LOOP_A) || (mode == `HWAC_OPMODE_LOOP_B);
	endfunction : is_loop_mode

	initial begin
		if (MAT_WIDTH < 2 || MAT_WIDTH > 63) begin
			$error("hw_activation_control MAT_WIDTH out of range");
		end
		if (MAT_CYCLES < 1 || MAT_CYCLES > ((64'h1 << MAT_WIDTH) - 64'h1)) begin
			$error("hw_activation_control MAT_CYCLES does not fit MAT_WIDTH");
		end
		if (`HWAC_PIN_COUNT != `HWAC_PIN_SEL_C + 1) begin
			$error("hw_activation_control pin bundle size mismatch");
		end
	end

	assign pins_raw[`HWAC_PIN_QUIET] = i_quiet;
	assign pins_raw[`HWAC_PIN_REQ] = i_activation_request_in;
	assign pins_raw[`HWAC_PIN_MASTER] = i_master_mode;
	assign pins_raw[`HWAC_PIN_LOOP] = i_loop_number_io;
	assign pins_raw[`HWAC_PIN_OPMODE_HI:`HWAC_PIN_OPMODE_LO] = i_operating_mode;
	assign pins_raw[`HWAC_PIN_SEL_A] = i_hw_mode_select_a;
	assign pins_raw[`HWAC_PIN_SEL_B] = i_hw_mode_select_b;
	assign pins_raw[`HWAC_PIN_SEL_C] = i_hw_mode_select_c;

	// All asynchronous pins share one synchroniser bank
	pin_sync #(
		.WIDTH(`HWAC_PIN_COUNT)
	) u_sync (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_pins(pins_raw),
		.o_pins(pins)
	);

	act_timer #(
		.WIDTH(MAT_WIDTH),
		.CYCLES(MAT_CYCLES)
	) u_timer (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.tmr(tmr_if)
	);

	assign quiet = pins[`HWAC_PIN_QUIET];
	assign req = pins[`HWAC_PIN_REQ];
	assign master = pins[`HWAC_PIN_MASTER];
	assign loop_in = pins[`HWAC_PIN_LOOP];
	assign opmode = pins[`HWAC_PIN_OPMODE_HI:`HWAC_PIN_OPMODE_LO];

	// Decoded from the filtered selects, so one select high leaves once it has passed the filter
	assign hw_mode = ~(pins[`HWAC_PIN_SEL_A] | pins[`HWAC_PIN_SEL_B] | pins[`HWAC_PIN_SEL_C]);
	assign loop_mode = is_loop_mode(opmode);

	// Until the pin bank has filled, a reset-low master pin reads as slave
	// and would turn the loop pin into an output against the master's driver
	always_comb begin
		settle_next = settle_reg;
		if (settle_reg != `HWAC_SETTLE_COUNT) begin
			settle_next = settle_reg + 3'h1;
		end
	end
	assign settled = (settle_reg == `HWAC_SETTLE_COUNT);

	// Edge seen from two successive filtered samples
	always_comb begin
		req_prev_next = req;
	end
	assign req_rise = req & ~req_prev_reg;

	// Start and stop sources: pins in hardware mode, control inputs otherwise.
	// The slave ignores the request pin; in hardware mode it wakes only from the line.
	always_comb begin
		start_req = 1'b0;
		stop_req = 1'b0;
		if (hw_mode) begin
			stop_req = quiet;
			if (!quiet) begin
				if (master) begin
					start_req = req_rise;
				end else begin
					start_req = i_line_wake;
				end
			end
		end else begin
			stop_req = i_sw_deactivate;
			start_req = i_sw_activate | (~master & i_line_wake);
		end
		// Nothing acts on pin values still filling the synchroniser
		if (!settled) begin
			start_req = 1'b0;
			stop_req = 1'b0;
		end
	end

	// Activation state machine
	always_comb begin
		state_next = state_reg;
		timeout_next = timeout_reg;
		tmr_if.start = 1'b0;
		tmr_if.stop = 1'b0;
		case (state_reg)
			hw_activation_pkg::ST_DEACTIVATED: begin
				// Further request edges are not looked at outside this state
				if (start_req && !stop_req) begin
					state_next = hw_activation_pkg::ST_ACTIVATING;
					tmr_if.start = master;
					timeout_next = 1'b0;
				end else begin
					// A count left over from an aborted start must never fire later
					tmr_if.stop = tmr_if.running;
				end
			end
			hw_activation_pkg::ST_ACTIVATING: begin
				if (stop_req) begin
					state_next = hw_activation_pkg::ST_DEACTIVATED;
					tmr_if.stop = 1'b1;
				end else if (i_train_done) begin
					state_next = hw_activation_pkg::ST_ACTIVE;
					tmr_if.stop = 1'b1;
				end else if (tmr_if.expired) begin
					// Expiry loses to completion in the same cycle
					state_next = hw_activation_pkg::ST_DEACTIVATED;
					timeout_next = 1'b1;
				end
			end
			hw_activation_pkg::ST_ACTIVE: begin
				if (stop_req || i_line_lost) begin
					state_next = hw_activation_pkg::ST_DEACTIVATED;
				end
			end
			default: begin
				state_next = hw_activation_pkg::ST_DEACTIVATED;
				tmr_if.stop = 1'b1;
			end
		endcase
	end

	// Loop number handling
	always_comb begin
		tx_loop_next = tx_loop_reg;
		tx_en_next = 1'b0;
		rx_loop_next = rx_loop_reg;
		pin_oe_n_next = 1'b1;
		valid_next = 1'b0;
		first_next = first_reg;
		if (master) begin
			// Captured as activation starts; the pin must already be stable
			if (state_reg == hw_activation_pkg::ST_DEACTIVATED) begin
				tx_loop_next = loop_in;
			end
			tx_en_next = loop_mode && (state_next != hw_activation_pkg::ST_DEACTIVATED);
			first_next = (tx_loop_next == `HWAC_LOOP_FIRST);
		end else begin
			if (state_next == hw_activation_pkg::ST_ACTIVE) begin
				rx_loop_next = i_rx_loop_number;
				valid_next = 1'b1;
			end
			// Pin becomes an output only for a slave in hardware mode
			pin_oe_n_next = ~(hw_mode & settled);
			first_next = (rx_loop_next == `HWAC_LOOP_FIRST);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_prev_reg <= 1'b0;
			settle_reg <= 3'h0;
		end else begin
			req_prev_reg <= req_prev_next;
			settle_reg <= settle_next;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= hw_activation_pkg::ST_DEACTIVATED;
			timeout_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timeout_reg <= timeout_next;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_loop_reg <= `HWAC_LOOP_FIRST;
			tx_en_reg <= 1'b0;
			rx_loop_reg <= `HWAC_LOOP_FIRST;
			pin_oe_n_reg <= 1'b1;
			valid_reg <= 1'b0;
			first_reg <= 1'b1;
		end else begin
			tx_loop_reg <= tx_loop_next;
			tx_en_reg <= tx_en_next;
			rx_loop_reg <= rx_loop_next;
			pin_oe_n_reg <= pin_oe_n_next;
			valid_reg <= valid_next;
			first_reg <= first_next;
		end
	end

	assign o_activating_flag_out = (state_reg == hw_activation_pkg::ST_ACTIVATING);
	assign o_deactivated = (state_reg == hw_activation_pkg::ST_DEACTIVATED);
	assign o_active = (state_reg == hw_activation_pkg::ST_ACTIVE);
	assign o_activation_timeout_flag = timeout_reg;
	assign o_hw_control_mode = hw_mode;
	assign o_tx_loop_number = tx_loop_reg;
	assign o_tx_loop_number_en = tx_en_reg;
	assign o_loop_number_io = rx_loop_reg;
	assign o_loop_number_io_oe_n = pin_oe_n_reg;
	assign o_loop_number_valid = valid_reg;
	assign o_first_loop = first_reg;
endmodule : hw_activation_control

// File: testbench/hw_activation_control_sva.sv
// Concurrent checks on the activation pin logic ports
module hw_activation_control_sva (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_quiet,
	input wire logic i_hw_mode_select_a,
	input wire logic i_hw_mode_select_b,
	input wire logic i_hw_mode_select_c,
	input wire logic [2:0] i_operating_mode,
	input wire logic o_loop_number_io,
	input wire logic o_tx_loop_number_en,
	input wire logic o_loop_number_valid,
	input wire logic o_first_loop,
	input wire logic o_activating_flag_out,
	input wire logic o_activation_timeout_flag,
	input wire logic o_hw_control_mode,
	input wire logic o_deactivated,
	input wire logic o_active
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);
	// Seven samples leave room for the pin synchroniser and one state edge
	sequence quiet_held;
		(i_quiet && o_hw_control_mode)[*7];
	endsequence
	sequence sel_high;
		(i_hw_mode_select_a || i_hw_mode_select_b || i_hw_mode_select_c)[*5];
	endsequence
	sequence sel_low;
		(!i_hw_mode_select_a && !i_hw_mode_select_b && !i_hw_mode_select_c)[*5];
	endsequence
	chk_quiet_forces_off: assert property (quiet_held |-> o_deactivated)
		else $error("quiet held but not deactivated");
	chk_flag_is_state: assert property (o_activating_flag_out == !(o_deactivated || o_active))
		else $error("activating flag differs from state");
	chk_valid_when_active: assert property (o_loop_number_valid |-> o_active)
		else $error("loop number valid outside active");
	chk_zero_first_loop: assert property (o_loop_number_valid |-> o_first_loop != o_loop_number_io)
		else $error("first loop flag wrong");
	chk_timeout_cause: assert property ($rose(o_activation_timeout_flag)
		|-> $past(o_activating_flag_out) && o_deactivated)
		else $error("timeout flag without activation expiry");
	chk_tx_mode_only: assert property (o_tx_loop_number_en |-> $past(i_operating_mode, 4) >= 3'h6)
		else $error("loop number sent in wrong mode");
	chk_sel_leaves_hw: assert property (sel_high |-> !o_hw_control_mode)
		else $error("select high but still hardware mode");
	chk_sel_low_hw: assert property (sel_low |-> o_hw_control_mode)
		else $error("selects low but not hardware mode");
endmodule : hw_activation_control_sva
bind hw_activation_control hw_activation_control_sva hw_activation_control_sva_i (.i_mclk, .i_rstn,
	.i_quiet, .i_hw_mode_select_a, .i_hw_mode_select_b, .i_hw_mode_select_c, .i_operating_mode,
	.o_loop_number_io, .o_tx_loop_number_en, .o_loop_number_valid, .o_first_loop,
	.o_activating_flag_out, .o_activation_timeout_flag, .o_hw_control_mode, .o_deactivated,
	.o_active);

// File: testbench/pin_ctrl_model.sv
// Local control logic model that drives the hardware-mode pins
module pin_ctrl_model (
	input wire logic i_mclk,
	output logic o_quiet,
	output logic o_req,
	output logic o_master,
	output logic [2:0] o_mode,
	output logic o_loop,
	output logic [2:0] o_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{o_quiet, o_req, o_mode, o_loop, o_sel} = 9'h0;
		o_master = 1'h1;
	end
	task set_pins(input logic q, input logic m, input logic [2:0] md, input logic lp);
		@(posedge i_mclk);
		o_quiet <= q;
		o_master <= m;
		o_mode <= md;
		// A released loop pin reads low through its pull-down
		o_loop <= m & lp;
	endtask : set_pins
	task request();
		@(posedge i_mclk);
		o_req <= o_master;
		repeat (6) @(posedge i_mclk);
		o_req <= 1'h0;
		repeat (4) @(posedge i_mclk);
	endtask : request
	task select(input logic [2:0] s);
		@(posedge i_mclk);
		o_sel <= s;
		repeat (6) @(posedge i_mclk);
	endtask : select
endmodule : pin_ctrl_model

// File: testbench/tb_hw_activation_control.sv
// Self-checking bench for the hardware-mode activation pin logic
module tb_hw_activation_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_rstn, wake, train, lost, rx, q, req, mst, lp, lp_out, oe_n, lp_wire;
	logic tx, tx_en, valid, first, acting, tmo, hw, deact, act;
	logic [2:0] mode, sel;
	int err_count, samples_checked;
	assign lp_wire = !oe_n ? lp_out : lp;
	pin_ctrl_model pin_ctrl_model_i (.i_mclk(i_mclk), .o_quiet(q), .o_req(req), .o_master(mst),
		.o_mode(mode), .o_loop(lp), .o_sel(sel));
	// Short timer keeps the expiry case within a few dozen cycles
	hw_activation_control #(.MAT_CYCLES(50)) hw_activation_control_i (.i_mclk(i_mclk),
		.i_rstn(i_rstn), .i_quiet(q), .i_activation_request_in(req), .i_hw_mode_select_a(sel[0]),
		.i_hw_mode_select_b(sel[1]), .i_hw_mode_select_c(sel[2]), .i_master_mode(mst),
		.i_operating_mode(mode), .i_loop_number_io(lp_wire), .o_loop_number_io(lp_out),
		.o_loop_number_io_oe_n(oe_n), .i_sw_activate(1'h0), .i_sw_deactivate(1'h0),
		.i_line_wake(wake), .i_train_done(train), .i_line_lost(lost), .i_rx_loop_number(rx),
		.o_tx_loop_number(tx), .o_tx_loop_number_en(tx_en), .o_loop_number_valid(valid),
		.o_first_loop(first), .o_activating_flag_out(acting), .o_activation_timeout_flag(tmo),
		.o_hw_control_mode(hw), .o_deactivated(deact), .o_active(act));
	initial begin
		i_mclk = 1'h0;
		forever #5 i_mclk = ~i_mclk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wait_st(input logic [2:0] s);
		int n;
		n = 0;
		// Never look in the step of the edge that moves the state
		@(negedge i_mclk);
		while ({act, acting, deact} !== s && n < 200) begin
			@(negedge i_mclk);
			n++;
		end
		chk({act, acting, deact}, s);
	endtask : wait_st
	task ev(input logic [2:0] e);
		@(posedge i_mclk);
		{wake, train, lost} <= e;
		@(posedge i_mclk);
		{wake, train, lost} <= 3'h0;
	endtask : ev
	task conclude();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	initial begin
		#100us;
		err_count++;
		conclude();
	end
	initial begin
		{wake, train, lost, rx} = 4'h0;
		i_rstn = 1'h0;
		err_count = 0;
		samples_checked = 0;
		repeat (6) @(posedge i_mclk);
		#1;
		chk({hw, deact, oe_n, first, acting, tmo, valid, tx_en}, 8'hF0);
		@(posedge i_mclk);
		i_rstn <= 1'h1;
		for (int m = 0; m < 8; m++) begin
			pin_ctrl_model_i.set_pins(1'h0, 1'h1, m[2:0], 1'h1);
			pin_ctrl_model_i.request();
			wait_st(3'h2);
			chk({tx_en, tx, first}, {m >= 6, 2'h2});
			pin_ctrl_model_i.set_pins(1'h1, 1'h1, m[2:0], 1'h1);
			wait_st(3'h1);
		end
		pin_ctrl_model_i.request();
		@(negedge i_mclk);
		chk({act, acting, deact}, 3'h1);
		$display("done: modes and quiet");
		pin_ctrl_model_i.set_pins(1'h0, 1'h1, 3'h7, 1'h0);
		pin_ctrl_model_i.request();
		wait_st(3'h2);
		chk({tx_en, tx, first}, 3'h5);
		ev(3'h2);
		wait_st(3'h4);
		pin_ctrl_model_i.request();
		@(negedge i_mclk);
		chk({act, acting, deact}, 3'h4);
		pin_ctrl_model_i.set_pins(1'h1, 1'h1, 3'h7, 1'h0);
		wait_st(3'h1);
		$display("done: master active");
		pin_ctrl_model_i.set_pins(1'h0, 1'h1, 3'h6, 1'h1);
		pin_ctrl_model_i.request();
		wait_st(3'h2);
		wait_st(3'h1);
		chk(tmo, 1'h1);
		pin_ctrl_model_i.request();
		wait_st(3'h2);
		chk(tmo, 1'h0);
		pin_ctrl_model_i.set_pins(1'h1, 1'h1, 3'h6, 1'h1);
		wait_st(3'h1);
		$display("done: timeout");
		pin_ctrl_model_i.set_pins(1'h0, 1'h0, 3'h6, 1'h0);
		rx <= 1'h1;
		// The slave and quiet-low pins must clear the synchroniser before the wake
		repeat (4) @(posedge i_mclk);
		ev(3'h4);
		wait_st(3'h2);
		ev(3'h2);
		wait_st(3'h4);
		@(negedge i_mclk);
		chk({oe_n, lp_wire, valid, first}, 4'h6);
		ev(3'h1);
		wait_st(3'h1);
		@(negedge i_mclk);
		chk(valid, 1'h0);
		$display("done: slave");
		for (int s = 0; s < 3; s++) begin
			pin_ctrl_model_i.select(3'h1 << s);
			chk(hw, 1'h0);
			pin_ctrl_model_i.select(3'h0);
			chk(hw, 1'h1);
		end
		$display("done: selects");
		conclude();
	end
endmodule : tb_hw_activation_control
